//--- design/timed_period_measure_mode_measure.sv
// Timed pulse period measurement channel with APB register access
// Summary of operation
// - Enable in mode plus the selected trigger starts measuring (TRIG_NONE: enable in mode alone)
// - Window length programmable, one tick resolution
// - Host selects rising or falling edge
// - First edge clears tick counter and sets edge counter to one
// - Tick counter advances every clock once timing after the first edge
// - Edge counter counts each chosen edge
// - Later edges latch tick count into hold
// - Window end publishes hold and count
// - New window opens immediately after publishing
// - Zero or one edge gives zero captures
// - Control register enable starts or stops
`timescale 1ns/1ps
module timed_period_measure_mode_measure (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pulseIn,
  input  wire logic        gateIn,
  input  wire logic        hwTrigIn,
  output logic             windowActive
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_FIRST,
    ST_TIMING
  } timed_period_measure_mode_state_t;

  timed_period_measure_mode_pkg::timed_period_measure_mode_ctl_t     ctl;
  timed_period_measure_mode_pkg::timed_period_measure_mode_capture_t capture;
  timed_period_measure_mode_state_t             state;
  logic [31:0]             windowLen;
  logic [31:0]             windowCnt;
  logic [31:0]             intervalTickCounter;
  logic [31:0]             edgeCountCounter;
  logic [31:0]             lastIntervalHold;
  logic                    pulseSync;
  logic                    pulsePrev;
  logic                    gateSync;
  logic                    gatePrev;
  logic                    hwSync;
  logic                    hwPrev;
  logic                    softTrig;
  logic                    chosenEdge;
  logic                    startEvent;
  logic                    windowEnd;
  logic                    wrEn;
  logic                    rdEn;
  logic                    running;

  function automatic logic addrKnown(input logic [7:0] a);
    addrKnown = (a == timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS) || (a == timed_period_measure_mode_pkg::WINDOW_LEN_OFS) ||
                (a == timed_period_measure_mode_pkg::CAPTURE_HIGH_OFS) || (a == timed_period_measure_mode_pkg::CAPTURE_LOW_OFS) ||
                (a == timed_period_measure_mode_pkg::STATUS_OFS) || (a == timed_period_measure_mode_pkg::TRIGGER_OFS);
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  timed_period_measure_mode_sync uPulseSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (pulseIn),
    .syncOut (pulseSync)
  );
  timed_period_measure_mode_sync uGateSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (gateIn),
    .syncOut (gateSync)
  );
  timed_period_measure_mode_sync uHwSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (hwTrigIn),
    .syncOut (hwSync)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulsePrev <= 1'b0;
      gatePrev  <= 1'b0;
      hwPrev    <= 1'b0;
    end else begin
      pulsePrev <= pulseSync;
      gatePrev  <= gateSync;
      hwPrev    <= hwSync;
    end
  end

  // Edge polarity chosen by host
  assign chosenEdge = ctl.fallingEdge ? (pulsePrev & ~pulseSync) : (~pulsePrev & pulseSync);

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait state; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrKnown(paddr);
  assign wrEn    = psel & penable & pwrite & addrKnown(paddr);
  assign rdEn    = psel & ~penable & ~pwrite;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl <= timed_period_measure_mode_pkg::timed_period_measure_mode_ctl_t'(timed_period_measure_mode_pkg::CONTROL_RESET[4:0]);
    end else if (wrEn && paddr == timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS) begin
      ctl.enable      <= pwdata[timed_period_measure_mode_pkg::CTL_ENABLE_BIT];
      ctl.modeSel     <= pwdata[timed_period_measure_mode_pkg::CTL_MODE_BIT];
      ctl.fallingEdge <= pwdata[timed_period_measure_mode_pkg::CTL_FALLING_BIT];
      ctl.trigSel     <= timed_period_measure_mode_pkg::timed_period_measure_mode_trig_t'(pwdata[timed_period_measure_mode_pkg::CTL_TRIGSEL_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      windowLen <= timed_period_measure_mode_pkg::WINDOW_RESET;
    end else if (wrEn && paddr == timed_period_measure_mode_pkg::WINDOW_LEN_OFS) begin
      // Shorter than the least window is clamped up to it
      windowLen <= (pwdata < timed_period_measure_mode_pkg::WINDOW_RESET) ? timed_period_measure_mode_pkg::WINDOW_RESET : pwdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      softTrig <= 1'b0;
    end else begin
      softTrig <= wrEn && paddr == timed_period_measure_mode_pkg::TRIGGER_OFS && pwdata[timed_period_measure_mode_pkg::TRIG_SOFT_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      case (paddr)
        timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS: prdata <= {27'h0000000, ctl.trigSel, ctl.fallingEdge, ctl.modeSel, ctl.enable};
        timed_period_measure_mode_pkg::WINDOW_LEN_OFS:      prdata <= windowLen;
        timed_period_measure_mode_pkg::CAPTURE_HIGH_OFS:    prdata <= capture.high;
        timed_period_measure_mode_pkg::CAPTURE_LOW_OFS:     prdata <= capture.low;
        timed_period_measure_mode_pkg::STATUS_OFS:          prdata <= {29'h00000000, running, state == ST_TIMING, windowActive};
        default:                       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Measurement sequencing
  // ****************************************
  always_comb begin
    case (ctl.trigSel)
      timed_period_measure_mode_pkg::TRIG_SOFT: startEvent = softTrig;
      timed_period_measure_mode_pkg::TRIG_HARD: startEvent = hwSync & ~hwPrev;
      timed_period_measure_mode_pkg::TRIG_GATE: startEvent = gateSync & ~gatePrev;
      default:             startEvent = 1'b1;
    endcase
  end

  assign windowEnd    = windowActive && (windowCnt == 32'h0000_0001);
  assign windowActive = state != ST_IDLE;

  // Triggers are only honoured while enabled in this mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      running <= 1'b0;
    end else if (!(ctl.enable && ctl.modeSel)) begin
      running <= 1'b0;
    end else if (startEvent) begin
      running <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:       state <= running ? ST_WAIT_FIRST : ST_IDLE;
        ST_WAIT_FIRST: begin
          if (!running) state <= ST_IDLE;
          else if (windowEnd) state <= ST_WAIT_FIRST;
          else if (chosenEdge) state <= ST_TIMING;
        end
        ST_TIMING:     begin
          if (!running) state <= ST_IDLE;
          else if (windowEnd) state <= ST_WAIT_FIRST;
        end
        default:       state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      windowCnt <= timed_period_measure_mode_pkg::WINDOW_RESET;
    end else if (state == ST_IDLE || windowEnd) begin
      windowCnt <= windowLen;
    end else begin
      windowCnt <= windowCnt - 32'h0000_0001;
    end
  end

  // ****************************************
  // Counters and hold
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intervalTickCounter <= 32'h0000_0000;
    end else if (state != ST_TIMING || windowEnd) begin
      intervalTickCounter <= 32'h0000_0000;
    end else begin
      intervalTickCounter <= intervalTickCounter + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || state == ST_IDLE || windowEnd) begin
      edgeCountCounter <= 32'h0000_0000;
    end else if (state == ST_WAIT_FIRST && chosenEdge) begin
      edgeCountCounter <= 32'h0000_0001;
    end else if (state == ST_TIMING && chosenEdge) begin
      edgeCountCounter <= edgeCountCounter + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || state == ST_IDLE || windowEnd) begin
      lastIntervalHold <= 32'h0000_0000;
    end else if (state == ST_TIMING && chosenEdge) begin
      lastIntervalHold <= intervalTickCounter + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capture <= '0;
    end else if (windowEnd) begin
      if (edgeCountCounter < 32'h0000_0002) begin
        capture <= '0;
      end else begin
        capture.high <= lastIntervalHold;
        capture.low  <= edgeCountCounter;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_capture_few;
    @(posedge ref_clk) disable iff (rst)
      (windowEnd && edgeCountCounter < 32'h0000_0002) |=> (capture.high == 32'h0 && capture.low == 32'h0);
  endproperty
  a_capture_few: assert property (p_capture_few) else $error("Capture not zero after sparse window");

  property p_capture_pub;
    @(posedge ref_clk) disable iff (rst)
      (windowEnd && edgeCountCounter >= 32'h0000_0002) |=>
        (capture.low == $past(edgeCountCounter) && capture.high == $past(lastIntervalHold));
  endproperty
  a_capture_pub: assert property (p_capture_pub) else $error("Capture does not match window results");

  property p_restart;
    @(posedge ref_clk) disable iff (rst)
      (windowEnd && running) |=> (state == ST_WAIT_FIRST && windowCnt == $past(windowLen));
  endproperty
  a_restart: assert property (p_restart) else $error("Window did not reopen");

  property p_first_edge;
    @(posedge ref_clk) disable iff (rst)
      (state == ST_WAIT_FIRST && chosenEdge && running && !windowEnd) |=>
        (intervalTickCounter == 32'h0 && edgeCountCounter == 32'h1 && state == ST_TIMING);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("First edge did not clear counters");

  property p_tick;
    @(posedge ref_clk) disable iff (rst)
      (state == ST_TIMING && !windowEnd && running) ##1 (state == ST_TIMING) |->
        intervalTickCounter == $past(intervalTickCounter) + 32'h1;
  endproperty
  a_tick: assert property (p_tick) else $error("Tick counter did not advance");

  property p_edge_count;
    @(posedge ref_clk) disable iff (rst)
      (state == ST_TIMING && chosenEdge && !windowEnd && running) |=>
        (edgeCountCounter == $past(edgeCountCounter) + 32'h1 && lastIntervalHold == $past(intervalTickCounter) + 32'h1);
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("Edge not counted or latched");

  property p_idle_tick;
    @(posedge ref_clk) disable iff (rst)
      (state == ST_WAIT_FIRST) |-> (intervalTickCounter == 32'h0 && lastIntervalHold == 32'h0);
  endproperty
  a_idle_tick: assert property (p_idle_tick) else $error("Tick or hold not idle before first edge");

  property p_disable;
    @(posedge ref_clk) disable iff (rst)
      !ctl.enable |=> ##1 (state == ST_IDLE);
  endproperty
  a_disable: assert property (p_disable) else $error("Disabled channel still measuring");

  property p_window_min;
    @(posedge ref_clk) disable iff (rst)
      windowLen >= timed_period_measure_mode_pkg::WINDOW_RESET;
  endproperty
  a_window_min: assert property (p_window_min) else $error("Window shorter than least length");

endmodule

//--- design/timed_period_measure_mode_pkg.sv
// Package: register map, field positions, reset values and timing for the period measure block
package timed_period_measure_mode_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CHANNEL_CONTROL_OFS = 8'h00;
  localparam logic [7:0] WINDOW_LEN_OFS      = 8'h04;
  localparam logic [7:0] CAPTURE_HIGH_OFS    = 8'h08;
  localparam logic [7:0] CAPTURE_LOW_OFS     = 8'h0C;
  localparam logic [7:0] STATUS_OFS          = 8'h10;
  localparam logic [7:0] TRIGGER_OFS         = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_ENABLE_BIT   = 0;
  localparam int CTL_MODE_BIT     = 1;
  localparam int CTL_FALLING_BIT  = 2;
  localparam int CTL_TRIGSEL_LSB  = 3;
  localparam int TRIG_SOFT_BIT    = 0;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;
  localparam real         CLK_PERIOD_NS   = 8.0;
  localparam real         MIN_WINDOW_NS   = 300.0;
  localparam real         TICK_NS         = 15.15;
  // Least window rounds up to whole clock cycles
  localparam int          MIN_WINDOW_CYC  = int'((MIN_WINDOW_NS + CLK_PERIOD_NS - 0.001) / CLK_PERIOD_NS);
  localparam logic [31:0] WINDOW_RESET    = 32'(MIN_WINDOW_CYC);
  localparam int          SYNC_STAGES     = 2;

  // Start source selection
  typedef enum logic [1:0] {
    TRIG_NONE,
    TRIG_SOFT,
    TRIG_HARD,
    TRIG_GATE
  } timed_period_measure_mode_trig_t;

  typedef struct packed {
    logic       enable;
    logic       modeSel;
    logic       fallingEdge;
    timed_period_measure_mode_trig_t trigSel;
  } timed_period_measure_mode_ctl_t;

  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
  } timed_period_measure_mode_capture_t;

endpackage

//--- design/timed_period_measure_mode_sync.sv
// Two flip-flop synchroniser for the asynchronous input pins
`timescale 1ns/1ps
module timed_period_measure_mode_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stageOne;

  // ****************************************
  // Synchroniser
  // ****************************************
  // First stage is read only by the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stageOne <= 1'b0;
      syncOut  <= 1'b0;
    end else begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end

endmodule

//--- tb/timed_period_measure_mode_measure_tb.sv
// Self-checking bench for the period measure channel
`timescale 1ns/1ps
module timed_period_measure_mode_measure_tb;
  typedef struct {logic fall; logic [15:0] half; logic [31:0] win;} timed_period_measure_mode_row_t;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        pulseIn, gateIn, hwTrigIn, windowActive, run, e;
  logic [7:0]  paddr;
  logic [15:0] halfCyc;
  logic [31:0] pwdata, prdata, r, lo, hi, lo2;
  int          err_count, checks_done, k, t;
  timed_period_measure_mode_row_t   rows [4] = '{'{1'b0, 16'h0004, 32'h0000_00C8}, '{1'b1, 16'h0005, 32'h0000_012C},
                            '{1'b0, 16'h0002, 32'h0000_0064}, '{1'b1, 16'h000D, 32'h0000_0190}};

  timed_period_measure_mode_measure dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulseIn(pulseIn), .gateIn(gateIn), .hwTrigIn(hwTrigIn), .windowActive(windowActive));
  timed_period_measure_mode_pulse_src src_u (.ref_clk(ref_clk), .run(run), .halfCyc(halfCyc), .pulseOut(pulseIn));

  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // ****************
  // Tasks
  // ****************
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, x, g);
    end
  endtask

  // Holds the whole request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Re-reads until both captures belong to one window
  task automatic capt(input logic [31:0] p, input logic [31:0] w, input logic zero);
    int n;
    n = 0;
    do begin
      rd(timed_period_measure_mode_pkg::CAPTURE_LOW_OFS); lo = r;
      rd(timed_period_measure_mode_pkg::CAPTURE_HIGH_OFS); hi = r;
      rd(timed_period_measure_mode_pkg::CAPTURE_LOW_OFS); lo2 = r;
      n++;
    end while (lo2 !== lo && n < 5);
    if (zero) begin
      chk("captLow", 32'h0000_0000, lo);
      chk("captHigh", 32'h0000_0000, hi);
    end else begin
      chk("captHigh", (lo - 32'h1) * p, hi);
      chk("lowRange", 32'h1, 32'(lo + 32'h1 >= w / p && lo <= w / p + 32'h1));
    end
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    gateIn = 1'b0; hwTrigIn = 1'b0; run = 1'b0; halfCyc = 16'h0004; err_count = 0; checks_done = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS); chk("control", timed_period_measure_mode_pkg::CONTROL_RESET, r);
    rd(timed_period_measure_mode_pkg::WINDOW_LEN_OFS); chk("window", timed_period_measure_mode_pkg::WINDOW_RESET, r);
    rd(timed_period_measure_mode_pkg::CAPTURE_HIGH_OFS); chk("captHigh", 32'h0, r);
    chk("active", 32'h0, 32'(windowActive));
    foreach (rows[i]) begin
      wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h0);
      halfCyc <= rows[i].half;
      run <= 1'b1;
      wr(timed_period_measure_mode_pkg::WINDOW_LEN_OFS, rows[i].win);
      wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h3 | (32'(rows[i].fall) << timed_period_measure_mode_pkg::CTL_FALLING_BIT));
      repeat (3 * rows[i].win) @(posedge ref_clk);
      chk("active", 32'h1, 32'(windowActive));
      rd(timed_period_measure_mode_pkg::STATUS_OFS); chk("status", 32'h0000_0005, r & 32'h0000_0005);
      capt(32'(rows[i].half) * 32'h2, rows[i].win, 1'b0);
    end
    // Below the least window the length clamps; sparse edges give zero
    wr(timed_period_measure_mode_pkg::WINDOW_LEN_OFS, 32'h5);
    rd(timed_period_measure_mode_pkg::WINDOW_LEN_OFS); chk("window", timed_period_measure_mode_pkg::WINDOW_RESET, r);
    halfCyc <= 16'h00A0;
    repeat (1000) @(posedge ref_clk);
    capt(32'h140, 32'h26, 1'b1);
    apb(1'b0, 8'h20, 32'h0); chk("pslverr", 32'h1, 32'(e)); chk("rdata", 32'h0, r);
    wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h0);
    wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h1);
    repeat (10) @(posedge ref_clk);
    chk("active", 32'h0, 32'(windowActive));
    for (t = 1; t < 4; t++) begin
      wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h0);
      wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h3 | (32'(t) << timed_period_measure_mode_pkg::CTL_TRIGSEL_LSB));
      repeat (10) @(posedge ref_clk);
      chk("active", 32'h0, 32'(windowActive));
      if (t == 1) begin
        wr(timed_period_measure_mode_pkg::TRIGGER_OFS, 32'h1);
      end else begin
        if (t == 2) hwTrigIn <= 1'b1;
        else gateIn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        hwTrigIn <= 1'b0;
        gateIn <= 1'b0;
      end
      k = 0;
      while (windowActive !== 1'b1 && k < 10) begin
        @(posedge ref_clk);
        k++;
      end
      chk("active", 32'h1, 32'(windowActive));
    end
    wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("active", 32'h0, 32'(windowActive));
    wr(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(timed_period_measure_mode_pkg::CHANNEL_CONTROL_OFS); chk("control", timed_period_measure_mode_pkg::CONTROL_RESET, r);
    chk("active", 32'h0, 32'(windowActive));
    conclude();
  end
endmodule

//--- tb/timed_period_measure_mode_pulse_src.sv
// Partner model: pulse train source driving the measured input pin
`timescale 1ns/1ps
module timed_period_measure_mode_pulse_src (
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic [15:0] halfCyc,
  output logic             pulseOut
);
  logic [15:0] cnt = 16'h0000;
  initial pulseOut = 1'b0;
  // Holds its level while stopped; half period kept at one clock or more
  always @(posedge ref_clk) begin
    if (!run) begin
      cnt <= 16'h0000;
    end else if (cnt + 16'h0001 >= halfCyc) begin
      cnt <= 16'h0000;
      pulseOut <= ~pulseOut;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule
